// >>> src/acs_pkg.sv
/*
  Package for the converter sequencer: register offsets, field positions,
  reset values and conversion timing counts.
  Assumes byte-wide registers on a plain strobe port with 3 address bits.
*/
package acs_pkg;
  // Register offsets (byte registers)
  localparam logic [2:0] OFS_RESULT_LOW = 3'h0;
  localparam logic [2:0] OFS_RESULT_HIGH = 3'h1;
  localparam logic [2:0] OFS_CTRL_A = 3'h2;
  localparam logic [2:0] OFS_CTRL_B = 3'h3;
  localparam logic [2:0] OFS_MUX_REF = 3'h4;

  // converter_control_status_a fields
  localparam int CSA_ENABLE = 7;
  localparam int CSA_START = 6;
  localparam int CSA_AUTO = 5;
  localparam int CSA_FLAG = 4;
  localparam int CSA_IE = 3;
  localparam int CSA_PRESC_LSB = 0;
  // converter_control_status_b fields
  localparam int CSB_TRIG_LSB = 0;
  // mux_reference_select_reg fields
  localparam int MUX_REF_LSB = 6;
  localparam int MUX_ALIGN = 5;
  localparam int MUX_CH_LSB = 0;

  // Trigger select code that chooses the converter's own completion flag
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;

  // Reset values
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [2:0] RST_TRIG_SEL = 3'h0;
  localparam logic [7:0] RST_MUX_REF = 8'h00;

  // Conversion timing in ADC clock cycles, kept as half cycles (x2)
  localparam logic [5:0] SH_NORM_HALF = 6'd3;    // 1.5 cycles
  localparam logic [5:0] LEN_NORM_HALF = 6'd26;  // 13 cycles
  localparam logic [5:0] SH_FIRST_HALF = 6'd27;  // 13.5 cycles
  localparam logic [5:0] LEN_FIRST_HALF = 6'd50; // 25 cycles
  localparam logic [5:0] SH_AUTO_HALF = 6'd4;    // 2 cycles after trigger
  localparam logic [5:0] LEN_AUTO_HALF = 6'd27;  // 13.5 cycles
  localparam logic [5:0] LAST_CYCLE_HALF = 6'd2; // final ADC cycle

  // CPU cycles of trigger synchronisation
  localparam int TRIG_SYNC_CYC = 3;

  // Prescaler counter reset value
  localparam logic [6:0] PRESC_RST = 7'h00;
endpackage : acs_pkg

// >>> src/acs_sequencer.sv
/*
  Conversion sequencer for a 10-bit successive approximation converter:
  register port, ADC clock prescaler, start/trigger logic, conversion timing,
  channel lock, result lock and completion flag.
  Assumes the converter core presents its result on conv_result in the cycle
  that core_sample_q/done timing closes, and that trigger inputs come from
  logic on sys_clk.
*/
// Implementation choices: the plain strobed port and the register addresses.
// Summary of operation
// RL1: Result is 10 bits over two bytes, right adjusted unless alignment bit set.
// RL2: Reading low byte blocks result updates until high byte read; blocked results lost.
// RL3: Completion flag is still set when a blocked result is discarded.
// RL4: Writing start bit begins conversion; bit stays one until hardware clears it.
// RL5: Channel written mid-conversion only applies after that conversion.
// RL6: With auto trigger on, selected rising trigger edge resets prescaler and starts.
// RL7: Trigger high at completion or edges during conversion start nothing.
// RL8: Software clears a flag used as trigger before it can trigger again.
// RL9: With own completion flag as trigger, conversions run continuously.
// RL10: Start bit still starts single conversions in auto mode; reads one while busy.
// RL11: Prescaler runs while enable set and is held reset while clear.
// RL12: ADC clock is CPU clock divided by ratio from prescaler select field.
// RL13: Software should pick ADC clock between 50 kHz and 200 kHz.
// RL14: Software start begins at next rising ADC clock edge.
// RL15: Normal conversion 13 ADC cycles; first after enable 25.
// RL16: Sample-and-hold at 1.5 cycles, or 13.5 for the first conversion.
// RL17: Completion writes result, sets flag, clears start bit in single mode.
// RL18: Auto-triggered sample 2 cycles after trigger, 3 sync cycles, 13.5 long.
// RL19: Free running restarts immediately after completion, start bit stays high.
// RL20: Reference and channel selections act only while enabled.
// RL21: Software clears the power-reduction bit before enabling the converter.
// RL22: Channel field routes any input, ground or bandgap as single-ended input.
// RL23: Selections track until start, lock during conversion, resume in last cycle.
// RL24: Interrupt requested while flag and enable set; writing one clears flag.
`timescale 1ns/10ps
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int TRIG_W = 8     // number of trigger source inputs
) (
  input wire logic sys_clk,             // 200 MHz CPU clock
  input wire logic rst_n,               // asynchronous reset, active low
  input wire logic [2:0] reg_addr,      // register address
  input wire logic [7:0] reg_wdata,     // write data
  input wire logic reg_wr,              // write strobe
  input wire logic reg_rd,              // read strobe
  output logic [7:0] reg_rdata_q,       // read data, cycle after strobe
  input wire logic [TRIG_W-1:0] trig_in, // on-chip trigger sources
  input wire logic [9:0] conv_result,   // converter core result
  output logic [3:0] core_channel_q,    // channel routed to the core
  output logic [1:0] core_reference_q,  // reference routed to the core
  output logic core_active_q,           // analog circuitry enabled
  output logic core_adc_clk_q,          // ADC clock level
  output logic core_start_q,            // conversion start pulse
  output logic core_sample_q,           // sample-and-hold pulse
  output logic irq_q                    // completion interrupt request
);

  // Divider mask: ratio 2^sel, with sel 0 also giving 2
  function automatic logic [6:0] presc_mask(input logic [2:0] sel);
    logic [7:0] ratio;
    ratio = 8'h01 << ((sel == 3'h0) ? 3'h1 : sel);
    presc_mask = 7'(ratio - 8'h01);
  endfunction : presc_mask

  logic enable_q, auto_q, ie_q, flag_q, pend_q, lock_q, align_q, busy_q, first_q;
  logic [2:0] presc_sel_q, trig_sel_q;
  logic [1:0] ref_reg_q;
  logic [3:0] ch_reg_q;
  logic [6:0] presc_q;
  logic [5:0] half_q, sh_q, len_q;
  logic [9:0] res_q;
  logic trig_prev_q;
  logic [TRIG_SYNC_CYC-1:0] trig_dly_q;

  logic wr_a, rd_lo, rd_hi, rise_tick, fall_tick, tick;
  logic trig_raw, trig_fire, free_run, done, sample, sw_start, start, restart;
  logic [6:0] mask;
  logic [5:0] half_nx;
  logic [15:0] res_view;

  assign wr_a = reg_wr && (reg_addr == OFS_CTRL_A);
  assign rd_lo = reg_rd && (reg_addr == OFS_RESULT_LOW);
  assign rd_hi = reg_rd && (reg_addr == OFS_RESULT_HIGH);

  // Prescaler ticks: rising ADC edge at wrap, falling edge half way
  assign mask = presc_mask(presc_sel_q);                          // [RL12]
  assign rise_tick = enable_q && (presc_q == mask);
  assign fall_tick = enable_q && (presc_q == (mask >> 1));
  assign tick = rise_tick || fall_tick;

  assign free_run = auto_q && (trig_sel_q == TRIG_FREE_RUN);
  assign trig_raw = (trig_sel_q == TRIG_FREE_RUN) ? 1'b0 : trig_in[trig_sel_q];
  // Edges seen while busy are dropped, not remembered
  assign trig_fire = trig_dly_q[TRIG_SYNC_CYC-1] && auto_q && enable_q && !busy_q; // [RL6] [RL7]

  assign half_nx = 6'(half_q + 6'd1);
  assign done = busy_q && tick && (half_nx == len_q);
  assign sample = busy_q && tick && (half_nx == sh_q);
  assign restart = done && free_run;                               // [RL9] [RL19]
  assign sw_start = rise_tick && (pend_q || restart) && (!busy_q || done) && !trig_fire; // [RL14] [RL10]
  assign start = sw_start || trig_fire;

  // Register configuration
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= RST_CTRL_A[CSA_ENABLE];
      auto_q <= RST_CTRL_A[CSA_AUTO];
      ie_q <= RST_CTRL_A[CSA_IE];
      presc_sel_q <= RST_CTRL_A[CSA_PRESC_LSB +: 3];
      trig_sel_q <= RST_TRIG_SEL;
      ref_reg_q <= RST_MUX_REF[MUX_REF_LSB +: 2];
      align_q <= RST_MUX_REF[MUX_ALIGN];
      ch_reg_q <= RST_MUX_REF[MUX_CH_LSB +: 4];
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFS_CTRL_A: begin
          enable_q <= reg_wdata[CSA_ENABLE];
          auto_q <= reg_wdata[CSA_AUTO];
          ie_q <= reg_wdata[CSA_IE];
          presc_sel_q <= reg_wdata[CSA_PRESC_LSB +: 3];
        end
        OFS_CTRL_B: trig_sel_q <= reg_wdata[CSB_TRIG_LSB +: 3];
        OFS_MUX_REF: begin
          ref_reg_q <= reg_wdata[MUX_REF_LSB +: 2];
          align_q <= reg_wdata[MUX_ALIGN];                          // [RL1]
          ch_reg_q <= reg_wdata[MUX_CH_LSB +: 4];                  // [RL22]
        end
        default: ;
      endcase
    end
  end

  // Prescaler: held reset while disabled, restarted by a trigger
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= PRESC_RST;
    end else if (!enable_q || trig_fire || presc_q == mask) begin // [RL11] [RL6]
      presc_q <= PRESC_RST;
    end else begin
      presc_q <= 7'(presc_q + 7'd1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_adc_clk_q <= 1'b0;
    end else if (!enable_q || trig_fire) begin
      core_adc_clk_q <= 1'b0;
    end else if (rise_tick) begin
      core_adc_clk_q <= 1'b1;
    end else if (fall_tick) begin
      core_adc_clk_q <= 1'b0;
    end
  end

  // Trigger edge detect plus synchronisation delay
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev_q <= 1'b0;
      trig_dly_q <= '0;
    end else begin
      trig_prev_q <= trig_raw;
      trig_dly_q <= {trig_dly_q[TRIG_SYNC_CYC-2:0], trig_raw && !trig_prev_q}; // [RL18]
    end
  end

  // Pending software start; reads as start bit together with busy
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
    end else if (wr_a && !reg_wdata[CSA_ENABLE]) begin
      pend_q <= 1'b0;
    end else if (wr_a && reg_wdata[CSA_START]) begin
      pend_q <= 1'b1;                                               // [RL4]
    end else if (start) begin
      pend_q <= 1'b0;
    end
  end

  // Conversion timing in half ADC cycles
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      half_q <= 6'd0;
      sh_q <= SH_NORM_HALF;
      len_q <= LEN_NORM_HALF;
      first_q <= 1'b1;
    end else if (!enable_q) begin
      busy_q <= 1'b0;                                               // [RL20]
      half_q <= 6'd0;
      first_q <= 1'b1;
    end else if (start) begin
      busy_q <= 1'b1;
      half_q <= 6'd0;
      first_q <= 1'b0;
      if (first_q) begin
        sh_q <= SH_FIRST_HALF;                                      // [RL15] [RL16]
        len_q <= LEN_FIRST_HALF;
      end else if (trig_fire) begin
        sh_q <= SH_AUTO_HALF;                                       // [RL18]
        len_q <= LEN_AUTO_HALF;
      end else begin
        sh_q <= SH_NORM_HALF;                                       // [RL15] [RL16]
        len_q <= LEN_NORM_HALF;
      end
    end else if (done) begin
      busy_q <= 1'b0;                                               // [RL17]
      half_q <= 6'd0;
    end else if (busy_q && tick) begin
      half_q <= half_nx;
    end
  end

  // Core strobes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_start_q <= 1'b0;
      core_sample_q <= 1'b0;
      core_active_q <= 1'b0;
    end else begin
      core_start_q <= start;
      core_sample_q <= sample;
      core_active_q <= enable_q;
    end
  end

  // Selections track until start, locked mid-conversion, free in last cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_channel_q <= RST_MUX_REF[MUX_CH_LSB +: 4];
      core_reference_q <= RST_MUX_REF[MUX_REF_LSB +: 2];
    end else if (enable_q && !start && (!busy_q || 6'(half_q + LAST_CYCLE_HALF) >= len_q)) begin // [RL23] [RL5] [RL20]
      core_channel_q <= ch_reg_q;
      core_reference_q <= ref_reg_q;
    end
  end

  // Result and read lock; a locked completion drops its result
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
    end else if (rd_hi) begin
      lock_q <= 1'b0;                                               // [RL2]
    end else if (rd_lo) begin
      lock_q <= 1'b1;                                               // [RL2]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_q <= 10'h000;
    end else if (done && !lock_q) begin
      res_q <= conv_result;                                         // [RL2] [RL17]
    end
  end

  // Completion flag: a new completion beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= RST_CTRL_A[CSA_FLAG];
    end else if (done) begin
      flag_q <= 1'b1;                                               // [RL3] [RL17]
    end else if (wr_a && reg_wdata[CSA_FLAG]) begin
      flag_q <= 1'b0;                                               // [RL24]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= flag_q && ie_q;                                      // [RL24]
    end
  end

  // Read port
  assign res_view = align_q ? {res_q, 6'h00} : {6'h00, res_q};      // [RL1]

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata_q <= 8'h00;
    end else begin
      unique case (reg_addr)
        OFS_RESULT_LOW: reg_rdata_q <= res_view[7:0];
        OFS_RESULT_HIGH: reg_rdata_q <= res_view[15:8];
        OFS_CTRL_A: reg_rdata_q <= {enable_q, pend_q || busy_q, auto_q, flag_q, ie_q, presc_sel_q}; // [RL10]
        OFS_CTRL_B: reg_rdata_q <= {5'h00, trig_sel_q};
        OFS_MUX_REF: reg_rdata_q <= {ref_reg_q, align_q, 1'b0, ch_reg_q};
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // Checks
  sequence s_sw_ready;
    enable_q && pend_q && !busy_q && rise_tick && !trig_fire;
  endsequence

  sequence s_running;
    busy_q && half_q == 6'd0;
  endsequence

  property p_sw_start;
    @(posedge sys_clk) disable iff (!rst_n) s_sw_ready |=> s_running ##1 !pend_q;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start not taken on ADC edge"); // [RL14]

  property p_done_len;
    @(posedge sys_clk) disable iff (!rst_n)
      done |-> (len_q == LEN_NORM_HALF || len_q == LEN_FIRST_HALF || len_q == LEN_AUTO_HALF) && half_nx == len_q;
  endproperty
  a_done_len: assert property (p_done_len) else $error("conversion ended at wrong length"); // [RL15]

  property p_sample_pos;
    @(posedge sys_clk) disable iff (!rst_n) core_sample_q |-> $past(busy_q) && $past(half_nx) == $past(sh_q);
  endproperty
  a_sample_pos: assert property (p_sample_pos) else $error("sample pulse at wrong instant"); // [RL16]

  property p_lock_hold;
    @(posedge sys_clk) disable iff (!rst_n) (lock_q && done && !rd_hi) |=> $stable(res_q);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("result changed while read-locked"); // [RL2]

  property p_flag_set;
    @(posedge sys_clk) disable iff (!rst_n) done |=> flag_q ##1 (irq_q == ie_q || !flag_q);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("completion flag or request missing"); // [RL3]

  property p_presc_hold;
    @(posedge sys_clk) disable iff (!rst_n) !enable_q [*2] |-> presc_q == PRESC_RST && !busy_q;
  endproperty
  a_presc_hold: assert property (p_presc_hold) else $error("prescaler ran while disabled"); // [RL11]

  property p_trig_ignored;
    @(posedge sys_clk) disable iff (!rst_n) (busy_q && !done && trig_dly_q[TRIG_SYNC_CYC-1]) |=> busy_q && half_q >= $past(half_q);
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("trigger restarted running conversion"); // [RL7]

  property p_chan_locked;
    @(posedge sys_clk) disable iff (!rst_n)
      (busy_q && !done && 6'(half_q + LAST_CYCLE_HALF) < len_q && 6'(half_q + 6'd3) < len_q) |=> $stable(core_channel_q);
  endproperty
  a_chan_locked: assert property (p_chan_locked) else $error("channel changed mid-conversion"); // [RL5]

  property p_free_run;
    @(posedge sys_clk) disable iff (!rst_n) (done && free_run && rise_tick && enable_q) |=> s_running;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free running did not restart"); // [RL19]

endmodule : acs_sequencer

// >>> verification/acs_core_model.sv
/*
  Behavioural converter core facing the sequencer.
  Assumes the sequencer's registered sample pulse and channel outputs.
*/
`timescale 1ns/10ps
module acs_core_model (
  input wire logic sys_clk, // CPU clock
  input wire logic rst_n, // async reset, active low
  input wire logic core_active_q, // analog enable
  input wire logic core_sample_q, // sample-and-hold pulse
  input wire logic [3:0] core_channel_q, // routed channel
  input wire logic [5:0] code_in, // low bits of the next result
  output logic [9:0] conv_result // converted value
);
  logic [9:0] held_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_q <= 10'h000;
    end else if (core_sample_q) begin
      held_q <= {core_channel_q, code_in}; // Channel seen at the sample instant
    end
  end

  // A powered-down core gives nothing usable, so show the inverse
  assign conv_result = core_active_q ? held_q : ~held_q;
endmodule : acs_core_model

// >>> verification/adc_conversion_sequencer_bench.sv
/*
  Self-checking bench for the conversion sequencer.
  Assumes acs_pkg, acs_sequencer and acs_core_model are compiled first.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module adc_conversion_sequencer_bench;
  import acs_pkg::*;
  typedef struct {string nm; logic [7:0] ex; logic [7:0] mk;} acs_note_t;
  localparam logic [7:0] EN = 8'h80;
  localparam logic [7:0] ST = 8'h40;
  localparam logic [7:0] AU = 8'h20;
  localparam logic [7:0] FL = 8'h10;
  localparam logic [7:0] IE = 8'h08;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] trig_in = 8'h00;
  logic [5:0] code = 6'h00;
  logic [7:0] reg_rdata_q;
  logic [9:0] conv_result;
  logic [3:0] core_channel_q;
  logic [1:0] core_reference_q;
  logic core_active_q;
  logic core_adc_clk_q;
  logic core_start_q;
  logic core_sample_q;
  logic irq_q;
  logic [4:0] ev;
  logic rd_seen = 1'b0;
  logic [9:0] res;
  logic [9:0] old;
  logic [3:0] ch;
  acs_note_t notes[$];
  int error_cnt = 0;
  int samples_checked = 0;
  int seed = 3;
  int start_cnt = 0;
  int n;
  int m;
  int k;

  always #2.5 sys_clk = ~sys_clk;

  acs_sequencer i_acs_sequencer (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .trig_in(trig_in), .conv_result(conv_result),
    .core_channel_q(core_channel_q), .core_reference_q(core_reference_q), .core_active_q(core_active_q),
    .core_adc_clk_q(core_adc_clk_q), .core_start_q(core_start_q), .core_sample_q(core_sample_q), .irq_q(irq_q));
  acs_core_model i_acs_core_model (.sys_clk(sys_clk), .rst_n(rst_n), .core_active_q(core_active_q),
    .core_sample_q(core_sample_q), .core_channel_q(core_channel_q), .code_in(code), .conv_result(conv_result));

  assign ev = {~core_adc_clk_q, core_adc_clk_q, irq_q, core_sample_q, core_start_q};

  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk) begin : monitor
    acs_note_t t;
    if (rd_seen && notes.size() > 0) begin
      t = notes.pop_front();
      `CHK(t.nm, t.ex & t.mk, reg_rdata_q & t.mk)
    end
    rd_seen <= reg_rd;
    if (core_start_q === 1'b1) start_cnt++;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input string nm, input logic [2:0] a, input logic [7:0] ex, input logic [7:0] mk);
    @(posedge sys_clk);
    notes.push_back('{nm, ex, mk});
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic wait_ev(input int b, output int c);
    c = 0;
    do begin
      @(posedge sys_clk);
      c++;
    end while (ev[b] !== 1'b1 && c < 600);
    if (c >= 600) `CHK("wait", 1, 0)
  endtask : wait_ev

  task automatic conv(input logic [7:0] ctl, input int sh);
    @(posedge sys_clk);
    code <= 6'($random(seed));
    wr(OFS_CTRL_A, ctl);
    wait_ev(0, n);
    wait_ev(1, n);
    `CHK("sample offset", sh, n)
    wait_ev(2, n);
    res = {core_channel_q, code};
  endtask : conv

  task automatic rd_res(input logic [9:0] r, input bit left);
    rd("low", OFS_RESULT_LOW, left ? {r[1:0], 6'h00} : r[7:0], 8'hff);
    rd("high", OFS_RESULT_HIGH, left ? r[9:2] : {6'h00, r[9:8]}, 8'hff);
  endtask : rd_res

  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  initial begin : watchdog
    #200000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    `CHK("active", 1'b0, core_active_q)
    rd("ctrl a", OFS_CTRL_A, RST_CTRL_A, 8'hff);
    rd("mux", OFS_MUX_REF, RST_MUX_REF, 8'hff);
    wr(3'h5, 8'hff);
    rd("unmapped", 3'h5, 8'h00, 8'hff);
    // Ratio 2 keeps the run short, far above the full-resolution clock range
    // Power reduction sits outside this block and is taken as cleared before enabling
    for (int s = 0; s < 8; s++) begin
      wr(OFS_CTRL_A, EN | 8'(s));
      wait_ev(4, n);
      wait_ev(3, n);
      wait_ev(4, n);
      wait_ev(3, m);
      `CHK("adc clk period", (s == 0) ? 2 : (1 << s), n + m)
    end
    wr(OFS_CTRL_A, 8'h00);
    wr(OFS_MUX_REF, 8'h45);
    @(posedge sys_clk);
    code <= 6'($random(seed));
    wr(OFS_CTRL_A, EN | ST | IE);
    wait_ev(0, n);
    wr(OFS_MUX_REF, 8'h49);
    `CHK("reference", 2'h1, core_reference_q)
    wait_ev(1, n);
    `CHK("locked channel", 4'h5, core_channel_q)
    `CHK("first sample", SH_FIRST_HALF, n + 2)
    rd("busy", OFS_CTRL_A, ST, ST);
    wait_ev(2, n);
    rd("done", OFS_CTRL_A, FL, ST | FL);
    rd_res({4'h5, code}, 1'b0);
    wr(OFS_CTRL_A, EN | IE | FL);
    repeat (2) @(posedge sys_clk);
    `CHK("irq cleared", 1'b0, irq_q)
    wr(OFS_MUX_REF, 8'h69);
    conv(EN | ST | IE, SH_NORM_HALF);
    `CHK("new channel", 4'h9, res[9:6])
    rd_res(res, 1'b1);
    wr(OFS_CTRL_A, EN | IE | FL);
    old = res;
    rd("lock low", OFS_RESULT_LOW, {old[1:0], 6'h00}, 8'hff);
    conv(EN | ST | IE, SH_NORM_HALF);
    `CHK("flag while locked", 1'b1, irq_q)
    rd("lock high", OFS_RESULT_HIGH, old[9:2], 8'hff);
    rd_res(old, 1'b1);
    wr(OFS_CTRL_A, EN | AU | IE | FL);
    for (int s = 1; s < 8; s++) begin
      wr(OFS_CTRL_B, 8'(s));
      @(posedge sys_clk);
      trig_in[s] <= 1'b1;
      wait_ev(0, n);
      wait_ev(1, n);
      `CHK("auto sample", SH_AUTO_HALF, n)
      @(posedge sys_clk);
      trig_in[s] <= 1'b0;
      rd("auto busy", OFS_CTRL_A, ST, ST);
      trig_in[s] <= 1'b1;
      wait_ev(2, n);
      k = start_cnt;
      wr(OFS_CTRL_A, EN | AU | IE | FL);
      repeat (80) @(posedge sys_clk);
      `CHK("no retrigger", k, start_cnt)
      trig_in[s] <= 1'b0;
    end
    conv(EN | AU | IE | ST, SH_NORM_HALF);
    wr(OFS_CTRL_B, 8'(TRIG_FREE_RUN));
    k = start_cnt;
    wr(OFS_CTRL_A, EN | AU | IE | ST | FL);
    // Let the request left by the earlier completion drop first
    repeat (2) @(posedge sys_clk);
    wait_ev(2, n);
    rd("free run busy", OFS_CTRL_A, ST, ST);
    repeat (90) @(posedge sys_clk);
    `CHK("free run starts", 1'b1, start_cnt >= k + 4)
    wr(OFS_CTRL_A, 8'h00);
    ch = core_channel_q;
    wr(OFS_MUX_REF, 8'h82);
    m = 0;
    repeat (20) begin
      @(posedge sys_clk);
      m += int'(core_adc_clk_q === 1'b1);
    end
    `CHK("clock held", 0, m)
    `CHK("disabled channel", ch, core_channel_q)
    `CHK("disabled reference", 2'h1, core_reference_q)
    `CHK("inactive", 1'b0, core_active_q)
    wrap_up();
  end
endmodule : adc_conversion_sequencer_bench
